// ===== common/mpl_pkg.sv
// Package: constants shared by the mark position latch block.
// Assumes a 40 MHz clock and word-aligned register offsets.
package mpl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_UP_LO = 8'h08;
    localparam logic [7:0] OFS_UP_HI = 8'h0C;
    localparam logic [7:0] OFS_DN_LO = 8'h10;
    localparam logic [7:0] OFS_DN_HI = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_RISE_POS = 8'h1C;
    localparam logic [7:0] OFS_FALL_POS = 8'h20;
    localparam logic [7:0] OFS_QUERY = 8'h24;
    localparam logic [7:0] OFS_REPLY = 8'h28;
    localparam logic [7:0] OFS_REPLY_INFO = 8'h2C;
    // Control register field positions
    localparam int CTRL_CMD_METHOD = 0;
    localparam int CTRL_FAST_PIN = 1;
    localparam int CTRL_FILT_LSB = 2;
    localparam int CTRL_DEGREE = 4;
    // Function select digit fields
    localparam int FSEL_ROLL_BIT = 4;
    localparam int FSEL_TOP_LSB = 12;
    // Query register fields
    localparam int QRY_CMD_LSB = 8;
    // Reset values
    localparam logic [15:0] FUNC_SEL_RST = 16'h0000;
    localparam logic signed [11:0] DIGITS_RST = 12'sh000;
    // Serial read command and its data numbers
    localparam logic [7:0] CMD_MARK_READ = 8'h1A;
    localparam logic [7:0] DNO_MAX = 8'h03;
    localparam logic [3:0] FRAME_LEN_DATA = 4'h8;
    localparam logic [3:0] FRAME_LEN_INFO = 4'hC;
    // Window arithmetic: limits in thousandths
    localparam logic [19:0] DIGIT_SCALE = 20'h003E8;
    localparam logic [19:0] DEG_FULL = 20'h57E40;
    // Capture time budget on the fast input path
    localparam int CLK_PERIOD_NS = 25;
    localparam int LATCH_TIME_NS = 400000;
    localparam int LATCH_CYC = LATCH_TIME_NS / CLK_PERIOD_NS;
    // Slow input path filter length, cycles
    localparam int SLOW_FILT_CYC = 200;
    // Longest fast filter, cycles
    localparam int FAST_FILT_MAX = 8;
endpackage

// ===== hdl/mpl_limit.sv
// Limit builder: turns two three-digit parts into one window limit.
// Assumes each part is held in -999..999 by software.
module mpl_limit (
    input wire logic signed [11:0] lo_digits,
    input wire logic signed [11:0] hi_digits,
    input wire logic degree,
    output logic signed [31:0] limit
);
    import mpl_pkg::*;

    logic neg; // Either part negative
    logic [19:0] mag; // Combined magnitude
    logic [19:0] m1; // Magnitude after one wrap
    logic [19:0] m2; // Magnitude after two wraps

    // Combine parts, then fold degrees into one turn
    always_comb begin
        neg = lo_digits[11] | hi_digits[11];
        mag = 20'((hi_digits[11] ? -hi_digits : hi_digits))
            * DIGIT_SCALE
            + 20'((lo_digits[11] ? -lo_digits : lo_digits));
        m1 = (mag >= DEG_FULL) ? mag - DEG_FULL : mag;
        m2 = (m1 >= DEG_FULL) ? m1 - DEG_FULL : m1;
        if (!degree) begin
            // Linear: sign taken from either part
            limit = neg ? -$signed({12'h000, mag}) : $signed({12'h000, mag});
        end else if (neg && m2 != 20'h00000) begin
            // Negative degrees land in the upper turn
            limit = $signed({12'h000, DEG_FULL - m2});
        end else begin
            limit = $signed({12'h000, m2});
        end
    end
endmodule

// ===== hdl/mpl_edge_filter.sv
// Edge filter for the mark-sense pin: synchroniser, glitch filter,
// and one-cycle rise and fall pulses. Assumes an asynchronous pin.
module mpl_edge_filter #(
    parameter int SLOW_CYC = mpl_pkg::SLOW_FILT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    input wire logic fast,
    input wire logic [1:0] filt_sel,
    output logic rise_evt,
    output logic fall_evt
);
    import mpl_pkg::*;

    // All state in one record
    typedef struct packed {
        logic sync1; // First stage, read by sync2 only
        logic sync2; // Second stage
        logic level; // Filtered level
        logic [15:0] cnt; // Stable-mismatch count
        logic rise; // Rise pulse
        logic fall; // Fall pulse
        logic [3:0] wait_n; // Fast-path wait length, for the check
    } mpl_filt_t;

    mpl_filt_t s_q;
    mpl_filt_t s_d;
    logic [15:0] need; // Cycles the new level must hold

    // Filter length: fast path keeps capture quick
    always_comb begin
        s_d = s_q;
        if (fast) begin
            need = (filt_sel == 2'h0) ? 16'h0000
                : 16'(16'h0001 << filt_sel);
        end else begin
            need = 16'(SLOW_CYC);
        end
        s_d.sync1 = pin;
        s_d.sync2 = s_q.sync1;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (s_q.sync2 == s_q.level) begin
            s_d.cnt = 16'h0000; // Bounce restarts the count
        end else if (s_q.cnt >= need) begin
            s_d.level = s_q.sync2;
            s_d.rise = s_q.sync2;
            s_d.fall = ~s_q.sync2;
            s_d.cnt = 16'h0000;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        // Cycles a new level waits on the fast path; saturates
        if (fast && s_q.sync2 != s_q.level) begin
            s_d.wait_n = (s_q.wait_n == 4'hF) ? s_q.wait_n
                : s_q.wait_n + 4'h1;
        end else begin
            s_d.wait_n = 4'h0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise_evt = s_q.rise;
    assign fall_evt = s_q.fall;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // A held new level on the fast path is taken in time;
    // a small counter keeps the check cheap for long waits
    chk_fast_latency: assert property (
        s_q.wait_n <= 4'(FAST_FILT_MAX + 1))
    else $error("fast path filter too slow");
endmodule

// ===== hdl/mpl_latch.sv
// Top of the mark position latch: register port, window check,
// rise/fall capture and serial read emulation.
// Assumes position and busy inputs are on clk; the pin is not.
//
// The strobed register port and the address map were chosen for this implementation.
module mpl_latch #(
    parameter int LATCH_LIMIT_CYC = mpl_pkg::LATCH_CYC,
    parameter int SLOW_CYC = mpl_pkg::SLOW_FILT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic mark_sense_input,
    input wire logic signed [31:0] actual_pos,
    input wire logic signed [31:0] start_pos,
    input wire logic homing_active,
    input wire logic manual_active,
    output logic rise_capture_done,
    output logic fall_capture_done,
    output logic parameter_error_alarm
);
    import mpl_pkg::*;

    // All state in one record
    typedef struct packed {
        logic [15:0] func_sel; // mark_function_select
        logic cmd_method; // command_method_select
        logic fast_pin; // fast_pin_assign
        logic [1:0] filt_sel; // fast_input_filter_select
        logic degree; // Degree unit
        logic signed [11:0] up_lo; // window_upper_low_digits
        logic signed [11:0] up_hi; // window_upper_high_digits
        logic signed [11:0] dn_lo; // window_lower_low_digits
        logic signed [11:0] dn_hi; // window_lower_high_digits
        logic signed [31:0] up_lim; // Built upper limit
        logic signed [31:0] dn_lim; // Built lower limit
        logic rise_done; // Rise capture flag
        logic fall_done; // Fall capture flag
        logic alarm; // Window setting error
        logic signed [31:0] rise_pos; // Rise latch
        logic signed [31:0] fall_pos; // Fall latch
        logic signed [31:0] reply; // Query answer data
        logic [3:0] reply_len; // Query frame length
        logic reply_ok; // Query understood
        logic [31:0] rdata; // Read data
    } mpl_top_t;

    mpl_top_t s_q;
    mpl_top_t s_d;
    logic signed [31:0] up_new; // Upper limit from digits
    logic signed [31:0] dn_new; // Lower limit from digits
    logic signed [31:0] pos_eff; // Position used for window
    logic in_win; // Position inside window
    logic can_cap; // Latching allowed now
    logic rise_evt; // Filtered rising edge
    logic fall_evt; // Filtered falling edge
    logic [7:0] q_cmd; // Query command byte
    logic [7:0] q_dno; // Query data number

    // Pin synchroniser and edge filter
    mpl_edge_filter #(
        .SLOW_CYC(SLOW_CYC)
    ) u_filter (
        .clk(clk),
        .reset(reset),
        .pin(mark_sense_input),
        .fast(s_q.fast_pin),
        .filt_sel(s_q.filt_sel),
        .rise_evt(rise_evt),
        .fall_evt(fall_evt)
    );

    // Upper limit builder
    mpl_limit u_up (
        .lo_digits(s_q.up_lo),
        .hi_digits(s_q.up_hi),
        .degree(s_q.degree),
        .limit(up_new)
    );

    // Lower limit builder
    mpl_limit u_dn (
        .lo_digits(s_q.dn_lo),
        .hi_digits(s_q.dn_hi),
        .degree(s_q.degree),
        .limit(dn_new)
    );

    // Window check against registered limits
    always_comb begin
        // Roll feed measures from the start position
        if (s_q.func_sel[FSEL_ROLL_BIT]) begin
            pos_eff = actual_pos - start_pos;
        end else begin
            pos_eff = actual_pos;
        end
        // cmd_method is not consulted here on purpose
        if (s_q.up_lim == s_q.dn_lim) begin
            in_win = 1'b1;
        end else if (s_q.up_lim > s_q.dn_lim) begin
            in_win = pos_eff >= s_q.dn_lim
                && pos_eff <= s_q.up_lim;
        end else if (s_q.degree) begin
            // Window runs through zero
            in_win = pos_eff >= s_q.dn_lim
                || pos_eff <= s_q.up_lim;
        end else begin
            in_win = 1'b0; // Alarm case, nothing taken
        end
        can_cap = s_q.func_sel[15:FSEL_TOP_LSB] == 4'h0
            && !homing_active && !manual_active
            && in_win;
    end

    assign q_cmd = wdata[QRY_CMD_LSB +: 8];
    assign q_dno = wdata[7:0];

    // Next state: registers, captures, query
    always_comb begin
        s_d = s_q;
        s_d.up_lim = up_new;
        s_d.dn_lim = dn_new;
        // Linear window upside down is a setting error
        s_d.alarm = !s_q.degree
            && s_q.up_lim < s_q.dn_lim;
        // Rising capture; flag left alone if already set
        if (rise_evt && can_cap) begin
            s_d.rise_pos = pos_eff;
            s_d.rise_done = 1'b1;
            s_d.fall_done = 1'b0;
        end
        // Falling capture ends the rise flag
        if (fall_evt && can_cap) begin
            s_d.fall_pos = pos_eff;
            s_d.fall_done = 1'b1;
            s_d.rise_done = 1'b0;
        end
        // Edges outside the window change nothing
        // Register writes
        if (wr) begin
            case (addr)
                OFS_FUNC_SEL: s_d.func_sel = wdata[15:0];
                OFS_CTRL: begin
                    s_d.cmd_method = wdata[CTRL_CMD_METHOD];
                    s_d.fast_pin = wdata[CTRL_FAST_PIN];
                    s_d.filt_sel = wdata[CTRL_FILT_LSB +: 2];
                    s_d.degree = wdata[CTRL_DEGREE];
                end
                OFS_UP_LO: s_d.up_lo = wdata[11:0];
                OFS_UP_HI: s_d.up_hi = wdata[11:0];
                OFS_DN_LO: s_d.dn_lo = wdata[11:0];
                OFS_DN_HI: s_d.dn_hi = wdata[11:0];
                OFS_QUERY: begin
                    // Serial read emulation, snapshot taken now
                    s_d.reply_ok = q_cmd == CMD_MARK_READ
                        && q_dno <= DNO_MAX;
                    s_d.reply = q_dno[0] ? s_q.fall_pos
                        : s_q.rise_pos;
                    if (q_cmd != CMD_MARK_READ || q_dno > DNO_MAX) begin
                        s_d.reply_len = 4'h0;
                    end else if (q_dno[1]) begin
                        s_d.reply_len = FRAME_LEN_INFO;
                    end else begin
                        s_d.reply_len = FRAME_LEN_DATA;
                    end
                end
                default: ; // Others read-only or unmapped
            endcase
        end
        // Register reads, data valid one cycle later only
        s_d.rdata = 32'h00000000;
        if (rd) begin
            case (addr)
                OFS_FUNC_SEL: s_d.rdata = {16'h0000, s_q.func_sel};
                OFS_CTRL: s_d.rdata = {27'h0000000, s_q.degree,
                    s_q.filt_sel, s_q.fast_pin, s_q.cmd_method};
                OFS_UP_LO: s_d.rdata = {20'h00000, s_q.up_lo};
                OFS_UP_HI: s_d.rdata = {20'h00000, s_q.up_hi};
                OFS_DN_LO: s_d.rdata = {20'h00000, s_q.dn_lo};
                OFS_DN_HI: s_d.rdata = {20'h00000, s_q.dn_hi};
                OFS_STATUS: s_d.rdata = {29'h00000000, s_q.alarm,
                    s_q.fall_done, s_q.rise_done};
                OFS_RISE_POS: s_d.rdata = s_q.rise_pos;
                OFS_FALL_POS: s_d.rdata = s_q.fall_pos;
                OFS_REPLY: s_d.rdata = s_q.reply;
                // Info: unit and roll feed as extra information
                OFS_REPLY_INFO: s_d.rdata = {24'h000000,
                    s_q.degree, s_q.func_sel[FSEL_ROLL_BIT],
                    s_q.reply_ok, 1'b0, s_q.reply_len};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.func_sel <= FUNC_SEL_RST;
            s_q.up_lo <= DIGITS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = s_q.rdata;
    assign rise_capture_done = s_q.rise_done;
    assign fall_capture_done = s_q.fall_done;
    assign parameter_error_alarm = s_q.alarm;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Capture steps
    sequence rise_taken;
        rise_evt && can_cap && !fall_evt;
    endsequence
    sequence fall_taken;
        fall_evt && can_cap;
    endsequence

    chk_rise_capture: assert property (
        rise_taken |=> s_q.rise_pos == $past(pos_eff) && s_q.rise_done)
    else $error("rise capture missed");

    chk_busy_suppress: assert property (
        (homing_active || manual_active) && (rise_evt || fall_evt)
        |=> $stable(s_q.rise_pos) && $stable(s_q.fall_pos))
    else $error("capture while busy");

    chk_func_select: assert property (
        s_q.func_sel[15:FSEL_TOP_LSB] != 4'h0 && (rise_evt || fall_evt)
        |=> $stable(s_q.rise_pos) && $stable(s_q.fall_pos)
        && $stable(s_q.rise_done))
    else $error("capture with other function");

    chk_window_gate: assert property (
        (rise_evt || fall_evt) && !in_win
        |=> $stable(s_q.rise_pos) && $stable(s_q.fall_pos))
    else $error("out-of-window edge changed latch");

    chk_alarm_linear: assert property (
        !s_q.degree && s_q.up_lim < s_q.dn_lim && !wr
        |=> parameter_error_alarm)
    else $error("window alarm not raised");

    chk_fall_clears: assert property (
        fall_taken |=> fall_capture_done && !rise_capture_done)
    else $error("fall capture flags wrong");

    // A set rise flag survives a new rise while the latch moves on
    chk_rise_keeps: assert property (
        rise_capture_done ##0 rise_taken
        |=> rise_capture_done && !fall_capture_done
        && s_q.rise_pos == $past(pos_eff))
    else $error("rise flag or latch wrong");

    chk_query_len: assert property (
        wr && addr == OFS_QUERY && q_cmd == CMD_MARK_READ
        && q_dno <= DNO_MAX
        |=> s_q.reply_len == (($past(q_dno) > 8'h01) ? 4'hC : 4'h8))
    else $error("query frame length wrong");

    // Query snapshot picks the latch named by the data number
    chk_query_data: assert property (
        wr && addr == OFS_QUERY && q_cmd == CMD_MARK_READ
        |=> s_q.reply == ($past(q_dno[0]) ? $past(s_q.fall_pos)
            : $past(s_q.rise_pos)))
    else $error("query reply data wrong");

    // Limits lag the unit bit by one cycle, hence the past value
    chk_degree_range: assert property (
        $past(s_q.degree) |-> s_q.up_lim >= 0 && s_q.dn_lim >= 0
        && s_q.up_lim < $signed({12'h000, DEG_FULL})
        && s_q.dn_lim < $signed({12'h000, DEG_FULL}))
    else $error("degree limit outside one turn");

    // Equal limits leave every position open
    chk_window_open: assert property (
        s_q.up_lim == s_q.dn_lim && rise_evt && !fall_evt
        && s_q.func_sel[15:FSEL_TOP_LSB] == 4'h0
        && !homing_active && !manual_active
        |=> s_q.rise_done && s_q.rise_pos == $past(pos_eff))
    else $error("open window refused a capture");
endmodule

// ===== sim/mpl_sensor_model.sv
// Mark sensor model: a clean sensor output that follows the bench's
// requested level after a fixed lag of LAG clock cycles.
// Assumes req changes just after a rising edge of clk.
module mpl_sensor_model #(
    parameter int LAG = 2
) (
    input wire logic clk,
    input wire logic req,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] dly_q = 8'h00; // Lag line, oldest level at the top

    // Lag line; a slow sensor still ends on a steady, glitch-free level
    always @(posedge clk) begin
        dly_q <= {dly_q[6:0], req};
    end

    assign pin = dly_q[LAG-1];
endmodule

// ===== sim/testbench.sv
// Testbench for the mark position latch: register-port host, sensor
// model and one task per scenario. Assumes a single 40 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mpl_pkg::*;

    logic clk = 1'b0; // Bench clock
    logic reset = 1'b1; // Synchronous reset
    logic [7:0] addr = 8'h00; // Register port
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic req = 1'b0; // Sensor level request
    logic pin; // Sensor output
    logic signed [31:0] actual_pos = 32'sh0; // Position feed
    logic signed [31:0] start_pos = 32'sh0;
    logic homing_active = 1'b0; // Motion busy inputs
    logic manual_active = 1'b0;
    logic rise_capture_done;
    logic fall_capture_done;
    logic parameter_error_alarm;
    int miscompares = 0; // Result counters
    int checks = 0;
    int cycles = 0;
    logic rf = 1'b0; // Expected flags, alarm and latched values
    logic ff = 1'b0;
    logic al = 1'b0;
    logic [31:0] rp = 32'h0;
    logic [31:0] fp = 32'h0;

    // 25 ns period
    always #12.5 clk = ~clk;

    // Short slow filter keeps runs brief; fast path is used in all but the last t_filter mark
    mpl_latch #(.SLOW_CYC(4)) mpl_latch_i (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .mark_sense_input(pin), .actual_pos(actual_pos),
        .start_pos(start_pos), .homing_active(homing_active),
        .manual_active(manual_active),
        .rise_capture_done(rise_capture_done),
        .fall_capture_done(fall_capture_done),
        .parameter_error_alarm(parameter_error_alarm));

    mpl_sensor_model #(.LAG(2)) mpl_sensor_model_i (.clk(clk),
        .req(req), .pin(pin));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 0;
        #1;
        d = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rreg(a, d);
        chk(d, exp);
    endtask

    // Move the sensor, then judge flags, latches, status and alarm;
    // 24 cycles is far inside the fast-path capture budget
    task automatic mark(input logic lvl, input int pos, input logic ok,
                        input int expv);
        @(posedge clk);
        actual_pos <= pos;
        req <= lvl;
        repeat (24) @(posedge clk);
        #1;
        if (ok && lvl) begin
            rf = 1'b1;
            ff = 1'b0;
            rp = 32'(expv);
        end else if (ok) begin
            ff = 1'b1;
            rf = 1'b0;
            fp = 32'(expv);
        end
        chk(32'(rise_capture_done), 32'(rf));
        chk(32'(fall_capture_done), 32'(ff));
        chk(32'(parameter_error_alarm), 32'(al));
        rchk(OFS_RISE_POS, rp);
        rchk(OFS_FALL_POS, fp);
        rchk(OFS_STATUS, {29'h0, al, ff, rf});
    endtask

    // Serial read emulation: data and frame length
    task automatic query(input logic [7:0] dno, input logic [31:0] ev,
                         input logic [3:0] len);
        wreg(OFS_QUERY, {16'h0, CMD_MARK_READ, dno});
        rchk(OFS_REPLY, ev);
        rchk(OFS_REPLY_INFO, {26'h0, 2'b10, len});
    endtask

    task automatic t_reset;
        rchk(OFS_STATUS, 32'h0);
        wreg(OFS_RISE_POS, 32'h0000FFFF);
        rchk(OFS_RISE_POS, 32'h0);
        rchk(8'h30, 32'h0);
        wreg(OFS_CTRL, 32'h00000002);
        $display("test reset done");
    endtask

    task automatic t_basic;
        mark(1'b1, 1234, 1'b1, 1234);
        mark(1'b0, 5678, 1'b1, 5678);
        for (int i = 0; i < 4; i++) begin
            query(8'(i), i[0] ? fp : rp,
                  i[1] ? FRAME_LEN_INFO : FRAME_LEN_DATA);
        end
        // Unknown command: no frame, not understood
        wreg(OFS_QUERY, {16'h0, 8'h1B, 8'h00});
        rchk(OFS_REPLY_INFO, 32'h0);
        $display("test basic done");
    endtask

    task automatic t_window;
        wreg(OFS_UP_HI, 32'h5);
        wreg(OFS_DN_HI, 32'h3);
        wreg(OFS_CTRL, 32'h00000003);
        mark(1'b1, 4000, 1'b1, 4000);
        mark(1'b0, 6000, 1'b0, 0);
        mark(1'b1, 4500, 1'b1, 4500);
        // Moving downward: lower side first avoids a false alarm
        wreg(OFS_DN_LO, 32'd500);
        wreg(OFS_DN_HI, 32'(-2));
        wreg(OFS_UP_HI, 32'(-1));
        mark(1'b0, -2000, 1'b1, -2000);
        wreg(OFS_UP_HI, 32'(-3));
        al = 1'b1;
        mark(1'b1, -2700, 1'b0, 0);
        wreg(OFS_UP_HI, 32'h0);
        wreg(OFS_DN_HI, 32'h0);
        wreg(OFS_DN_LO, 32'h0);
        al = 1'b0;
        $display("test window done");
    endtask

    task automatic t_inhibit;
        @(posedge clk);
        homing_active <= 1'b1;
        mark(1'b0, 777, 1'b0, 0);
        @(posedge clk);
        homing_active <= 1'b0;
        manual_active <= 1'b1;
        mark(1'b1, 778, 1'b0, 0);
        @(posedge clk);
        manual_active <= 1'b0;
        wreg(OFS_FUNC_SEL, 32'h00001000);
        mark(1'b0, 779, 1'b0, 0);
        wreg(OFS_FUNC_SEL, 32'h0);
        mark(1'b1, 800, 1'b1, 800);
        $display("test inhibit done");
    endtask

    // Travel from start lands inside, distance from home does not
    task automatic t_roll;
        @(posedge clk);
        start_pos <= 100000;
        wreg(OFS_UP_HI, 32'd500);
        wreg(OFS_DN_HI, 32'd300);
        wreg(OFS_FUNC_SEL, 32'h00000010);
        mark(1'b0, 550000, 1'b1, 450000);
        mark(1'b1, 650000, 1'b0, 0);
        wreg(OFS_FUNC_SEL, 32'h0);
        $display("test roll done");
    endtask

    // Lower 315 above upper 450 (folds to 90): window wraps zero
    task automatic t_degree;
        wreg(OFS_CTRL, 32'h00000012);
        wreg(OFS_DN_HI, 32'd315);
        wreg(OFS_UP_HI, 32'd450);
        mark(1'b0, 10000, 1'b1, 10000);
        mark(1'b1, 200000, 1'b0, 0);
        mark(1'b0, 350000, 1'b1, 350000);
        $display("test degree done");
    endtask

    // Longest fast filter, a glitch it must drop, then the slow path
    task automatic t_filter;
        wreg(OFS_UP_HI, 32'h0);
        wreg(OFS_DN_HI, 32'h0);
        wreg(OFS_CTRL, 32'h0000000E);
        mark(1'b1, 1111, 1'b1, 1111);
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        req <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk(32'(fall_capture_done), 32'(ff));
        chk(32'(rise_capture_done), 32'(rf));
        wreg(OFS_CTRL, 32'h00000000);
        mark(1'b0, 2222, 1'b1, 2222);
        $display("test filter done");
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 700 cycles of the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_basic();
        t_window();
        t_inhibit();
        t_roll();
        t_degree();
        t_filter();
        end_sim();
    end
endmodule
